/* File: hdl/fwg_pkg.sv */
// Functional notes
// - one entry address selects all functions
// - key cleared after every processed call
// - keyed call without key resets controller
// - activate bit zero forces write permit set
// - activate bit one: permit follows commands
// - command 08H then key sets permit
// - command 0BH then key, or reset, clears
// - protection only in serial/application modes
// - routine clears permit after every write (code: erase leaves it set)
// - serial programming sets permit before routines
// - config lock bit refuses configuration writes
// - lock set by programming, cleared by command
// - lock clear disable blocks command in ISP/IAP
// - disable bit cleared by command in ICP/parallel
// - cpu held idle during self-timed cycle
// - interrupt aborts running cycle
// - error sets carry and returns status
// - bit0 interrupted; bits 4..7 read zero
// - bit1 security refusal, memory unchanged
// - bit2 high voltage fault aborts cycle
// - bit3 read-back mismatch after programming
// - status in R7; carry clear on success
package fwg_pkg;
  localparam logic [15:0] ENTRY_ADDR = 16'hff03;
  localparam logic [7:0] KEY_VALUE = 8'h96;
  localparam logic [7:0] KEY_RAM_ADDR = 8'hff;
  localparam logic [7:0] CMD_SET_WE = 8'h08;
  localparam logic [7:0] CMD_CLR_WE = 8'h0b;
  localparam int BIT_ACTIVATE = 7;
  localparam int BIT_CFG_LOCK = 6;
  localparam int BIT_LOCK_DIS = 7;
  localparam int ST_OI = 0;
  localparam int ST_SV = 1;
  localparam int ST_HVE = 2;
  localparam int ST_VE = 3;
  // axi register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_KEYDATA = 8'h08;
  localparam logic [7:0] A_BOOTST = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_CYCLE = 8'h14;
  localparam logic [7:0] BOOTST_RST = 8'h00;
  localparam logic [15:0] CYCLE_RST = 16'h0010;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    FWG_IDLE = 2'b00, FWG_RUN = 2'b01, FWG_DONE = 2'b11
  } fwg_state_e;
  typedef enum logic [1:0] {
    OP_PROG = 2'b00, OP_ERASE = 2'b01, OP_CRC = 2'b10, OP_CFG = 2'b11
  } fwg_op_e;
  typedef struct packed {
    logic carry;
    logic [7:0] status;
  } fwg_result_s;
endpackage

/* File: hdl/fwg_guard.sv */
`timescale 1ns/1ps
module fwg_guard import fwg_pkg::*; (
  input wire logic clk, // 200 MHz
  input wire logic arst_n, // async reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic call_req, // pulse: call made, to any call_addr
  input wire logic [15:0] call_addr, // address of the call
  input wire logic [1:0] call_op, // operation selected by regs
  input wire logic call_keyed, // function needs the key
  input wire logic call_cfg, // target is a config byte
  input wire logic key_ram_we, // internal ram write strobe
  input wire logic [7:0] key_ram_addr, // internal ram address
  input wire logic [7:0] key_ram_data, // internal ram data
  input wire logic isp_mode, // serial programming active
  input wire logic icp_mode, // pin (async): circuit/parallel
  input wire logic irq_pin, // pin (async): interrupt
  input wire logic hv_fault_pin, // pin (async): hv fault
  input wire logic secure_deny, // security blocks this op
  input wire logic readback_ok, // read-back matched
  output logic cpu_idle, // cpu held in program idle
  output logic mem_write, // pulse: commit flash write
  output logic result_valid, // pulse: result ready
  output logic result_carry, // carry flag value
  output logic [7:0] result_status, // status byte for R7
  output logic mcu_reset, // pulse: reset controller
  output logic write_permit // internal write permit flag
);

  // flash write guard: holds the enable flag, the boot status
  // byte and the call key, runs the self-timed cycle and forms
  // the status byte with its carry. the cpu side is reduced to
  // a call strobe with its operands and a result strobe.

  ////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops each, only the second is read;
  // icp, irq and hv come from pins, the rest share this clock
  localparam int N_SYNC = 3;
  logic [N_SYNC-1:0] sync_in;
  logic [N_SYNC-1:0] sync_out;
  assign sync_in = {hv_fault_pin, irq_pin, icp_mode};
  for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
    logic q1;
    logic q2;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        q1 <= 1'b0;
        q2 <= 1'b0;
      end else begin
        q1 <= sync_in[g];
        q2 <= q1;
      end
    end
    assign sync_out[g] = q2;
  end
  wire icp = sync_out[0];
  wire irq = sync_out[1];
  wire hv = sync_out[2];

  ////////////////////////////////////////////////////////////////
  // axi lite slave: one write and one read in flight
  // map (byte offsets, one word each, byte in the low lanes):
  //   00 ctrl: write bit 0 asks for a lock clear; reads
  //      {key valid, permit, enable flag} in bits 2:0
  //   04 command byte, armed for the very next write only
  //   08 key data byte, write only, reads zero
  //   0c boot status byte: bit 7 activate/clear-disable,
  //      bit 6 config lock
  //   10 status: result byte, carry at 8, state at 10:9
  //   14 run length of the self-timed cycle, 16 bits
  // unmapped offsets answer slverr and read zero.
  // writes need strobe 0 (run length both low strobes); other
  // strobes alone are answered but change nothing.
  // write and data beats are parked separately, so the master
  // may offer them in either order; the response waits for both
  // and for the previous response to be taken.
  logic aw_held, w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      // ready drops for the cycle after a handshake, so a held beat
      // is never overwritten before the response has been formed
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_q) ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic addr_ok(input logic [7:0] a);
    return a == A_CTRL || a == A_CMD || a == A_KEYDATA ||
      a == A_BOOTST || a == A_STATUS || a == A_CYCLE;
  endfunction
  wire wr_lo = wr_go && ws_q[0];
  wire wr_cmd = wr_lo && aw_q == A_CMD;
  wire wr_key = wr_lo && aw_q == A_KEYDATA;
  wire wr_boot = wr_lo && aw_q == A_BOOTST;
  wire wr_ctrl = wr_lo && aw_q == A_CTRL;
  wire wr_cyc = wr_go && aw_q == A_CYCLE && ws_q[1:0] == 2'b11;
  ////////////////////////////////////////////////////////////////
  // command then key sequence and write permit
  logic [7:0] cmd_reg;
  logic cmd_armed;
  logic [7:0] boot_status;
  logic [15:0] cycle_len;
  fwg_state_e state;
  fwg_op_e op;
  logic op_cfg, op_keyed;
  // a command only counts when the key is the very next write
  function automatic logic key_seq(input logic [7:0] cmd);
    return cmd_armed && cmd_reg == cmd && w_q[7:0] == KEY_VALUE;
  endfunction

  wire seq_set = wr_key && key_seq(CMD_SET_WE);
  wire seq_clr = wr_key && key_seq(CMD_CLR_WE);
  // the armed mark dies with any other completed write, even to
  // an unmapped offset, so a stray write between command and key
  // cannot leave a half sequence waiting
  wire done_write = state == FWG_DONE && (op == OP_PROG || op_cfg);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= 8'h00;
      cmd_armed <= 1'b0;
    end else if (wr_cmd) begin
      cmd_reg <= w_q[7:0];
      cmd_armed <= 1'b1;
    end else if (wr_go) begin
      cmd_armed <= 1'b0;
    end
  end

  // set wins over clear in one cycle: a serial session that
  // arms the flag must not lose it to a finishing write
  logic we_flag;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      we_flag <= 1'b0;
    end else if (seq_set || (isp_mode && call_req)) begin
      we_flag <= 1'b1;
    end else if (seq_clr || done_write) begin
      we_flag <= 1'b0;
    end
  end
  // forced high while activation bit is low
  wire permit = !boot_status[BIT_ACTIVATE] || we_flag;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) write_permit <= 1'b0;
    else write_permit <= permit;
  end
  ////////////////////////////////////////////////////////////////
  // boot status byte; lock clear via ctrl bit 0
  // bit 7 has two meanings at once: it turns the enable flag
  // into a user-controlled one and it also bars the lock clear
  // outside circuit/parallel programming. a lock clear in those
  // modes drops both lock and bar; an ordinary byte write there
  // is not gated by permit or lock at all.
  wire lock_clr_req = wr_ctrl && w_q[0];
  wire lock_clr_ok = icp || !boot_status[BIT_LOCK_DIS];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_status <= BOOTST_RST;
    end else if (lock_clr_req && lock_clr_ok) begin
      boot_status[BIT_CFG_LOCK] <= 1'b0;
      if (icp) boot_status[BIT_LOCK_DIS] <= 1'b0;
    end else if (wr_boot && (icp || (permit &&
        !boot_status[BIT_CFG_LOCK]))) begin
      boot_status <= w_q[7:0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    // software sets the run length; zero still gives one clock
    // of run, so a cycle can never be skipped
    if (!arst_n) cycle_len <= CYCLE_RST;
    else if (wr_cyc) cycle_len <= w_q[15:0];
  end
  ////////////////////////////////////////////////////////////////
  // authorization key in ram location ff
  // calls are taken only at the one entry address and only while
  // idle; a call that arrives mid-cycle is not queued
  logic key_valid;
  wire accept = call_req && call_addr == ENTRY_ADDR &&
    state == FWG_IDLE;
  // a ram write in the call's own cycle re-arms the key: setting
  // wins, and the check below has already used the old value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_valid <= 1'b0;
    end else if (key_ram_we && key_ram_addr == KEY_RAM_ADDR) begin
      key_valid <= key_ram_data == KEY_VALUE;
    end else if (accept) begin
      key_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    // a keyed call with no key never starts a cycle; the reset
    // pulse is the only answer it gets, and the caller is gone
    // before any status could be read
    if (!arst_n) mcu_reset <= 1'b0;
    else mcu_reset <= accept && call_keyed && !key_valid;
  end
  ////////////////////////////////////////////////////////////////
  // self-timed cycle
  logic [15:0] cnt;
  logic [7:0] st;
  // the serial session sets the flag as it enters, so its own
  // first call must not be refused for the flag it is setting
  wire permit_now = permit || isp_mode;
  wire refuse = !icp && (!permit_now ||
    (call_cfg && boot_status[BIT_CFG_LOCK]));

  // idle -> run -> done -> idle, one bit per step except done -> idle. a refused
  // call skips run and reports at once. inside run an interrupt
  // beats a voltage fault, which beats normal completion, so an
  // aborted cycle never commits. the run lasts cycle_len + 1
  // clocks, counted down to zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= FWG_IDLE;
      op <= OP_PROG;
      op_cfg <= 1'b0;
      op_keyed <= 1'b0;
      cnt <= 16'h0;
      st <= 8'h00;
    end else begin
      unique case (state)
        FWG_IDLE: begin
          if (accept && !(call_keyed && !key_valid)) begin
            op <= fwg_op_e'(call_op);
            op_cfg <= call_cfg;
            op_keyed <= call_keyed;
            cnt <= cycle_len;
            st <= 8'h00;
            st[ST_SV] <= (call_keyed && refuse) || secure_deny;
            state <= ((call_keyed && refuse) || secure_deny) ?
              FWG_DONE : FWG_RUN;
          end
        end
        FWG_RUN: begin
          // cnt wraps when it is decremented at zero on the last run clock; it is reloaded on entry,
          // so a stale count never shortens the next cycle
          cnt <= cnt - 16'h1;
          if (irq) begin
            st[ST_OI] <= 1'b1;
            state <= FWG_DONE;
          end else if (hv) begin
            st[ST_HVE] <= 1'b1;
            state <= FWG_DONE;
          end else if (cnt == 16'h0) begin
            if (op == OP_PROG && !op_cfg && !readback_ok)
              st[ST_VE] <= 1'b1;
            state <= FWG_DONE;
          end
        end
        FWG_DONE: state <= FWG_IDLE;
        default: state <= FWG_IDLE;
      endcase
    end
  end
  // results are held until the next call so firmware can read
  // them late; the valid and commit lines are one-cycle pulses

  // commit only at a clean end: crc never writes memory, and an
  // unkeyed call never touches it
  wire commit_now = state == FWG_RUN && cnt == 16'h0 && !irq && !hv &&
    op_keyed && op != OP_CRC;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cpu_idle <= 1'b0;
    else cpu_idle <= state == FWG_RUN && !irq;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mem_write <= 1'b0;
    else mem_write <= commit_now;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) result_valid <= 1'b0;
    else result_valid <= state == FWG_DONE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_carry <= 1'b0;
      result_status <= 8'h00;
    end else if (state == FWG_DONE) begin
      result_status <= {4'h0, st[3:0]};
      result_carry <= |st[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // arready is raised only after a cycle in which it was low, which
  // keeps the address decode registered and costs a cycle on
  // back-to-back reads
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    unique case (a)
      A_CTRL: w = {29'h0, key_valid, permit, we_flag};
      A_CMD: w = {24'h0, cmd_reg};
      A_BOOTST: w = {24'h0, boot_status};
      A_STATUS: w = {21'h0, state, result_carry, result_status};
      A_CYCLE: w = {16'h0, cycle_len};
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OK : RESP_SLVERR;
        s_axi_rdata <= read_word(s_axi_araddr);
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: verification/fwg_guard_chk.sv */
`timescale 1ns/1ps
module fwg_guard_chk import fwg_pkg::*; (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic call_req, // call
  input wire logic [15:0] call_addr, // address
  input wire logic [1:0] call_op, // op
  input wire logic call_keyed, // keyed
  input wire logic call_cfg, // cfg
  input wire logic irq_pin, // irq
  input wire logic secure_deny, // deny
  input wire logic cpu_idle, // idle
  input wire logic mem_write, // commit
  input wire logic result_valid, // result
  input wire logic result_carry, // carry
  input wire logic [7:0] result_status, // status
  input wire logic mcu_reset // reset out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  sequence crc_call;
    call_req && call_addr == ENTRY_ADDR && !cpu_idle && !call_keyed &&
      !call_cfg && call_op == OP_CRC && !secure_deny && !irq_pin;
  endsequence
  sequence bad_call;
    call_req && call_addr != ENTRY_ADDR && !cpu_idle;
  endsequence
  run_start_a: assert property (crc_call |-> ##2 cpu_idle)
    else $error("call did not idle cpu");
  idle_end_a: assert property ($fell(cpu_idle) |-> ##[0:2] result_valid)
    else $error("no result after run");
  hi_zero_a: assert property (result_valid |-> result_status[7:4] == 4'h0)
    else $error("status high nibble set");
  carry_err_a: assert property (result_valid |->
    result_carry == (result_status != 8'h00))
    else $error("carry disagrees with status");
  commit_ok_a: assert property (mem_write |->
    ##[0:2] (result_valid && result_status[2:0] == 3'h0))
    else $error("commit with abort status");
  irq_abort_a: assert property (irq_pin && cpu_idle |-> ##[1:6] !cpu_idle)
    else $error("irq did not abort");
  irq_flag_a: assert property ($rose(irq_pin) && cpu_idle |->
    ##[1:8] (result_valid && result_status[ST_OI]))
    else $error("abort not flagged");
  no_key_a: assert property (mcu_reset |-> ##1 !cpu_idle [*2])
    else $error("run despite missing key");
  entry_only_a: assert property (bad_call |->
    ##1 !mcu_reset ##1 !cpu_idle)
    else $error("call off entry accepted");
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb import fwg_pkg::*;;
  logic clk = '0, arst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic call_req = '0, call_keyed = '0, call_cfg = '0, key_ram_we = '0;
  logic [15:0] call_addr = '0;
  logic [1:0] call_op = '0;
  logic [7:0] key_ram_addr = '0, key_ram_data = '0;
  logic isp_mode = '0, icp_mode = '0, irq_pin = '0, hv_fault_pin = '0;
  logic secure_deny = '0, readback_ok = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_idle, mem_write, result_valid, result_carry;
  logic mcu_reset, write_permit;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] result_status;
  logic [8:0] res;
  int err_count = 0, n_compared = 0, cyc = 0, mw = 0, rs = 0, m0, r0;
  fwg_guard i_dut (.*);
  always #2.5 clk = ~clk;
  // tally pulses so tests compare counts, not edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mw <= mw + mem_write;
    rs <= rs + mcu_reset;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task setp(input logic [7:0] c);
    axw(A_CMD, {24'h0, c});
    axw(A_KEYDATA, {24'h0, KEY_VALUE});
  endtask
  task key();
    key_ram_we <= 1'b1;
    key_ram_addr <= KEY_RAM_ADDR;
    key_ram_data <= KEY_VALUE;
    @(posedge clk);
    key_ram_we <= 1'b0;
    @(posedge clk);
  endtask
  // abort pins rise mid-run, well inside the default cycle length
  task automatic call(input logic [1:0] op, input logic kd, dn, ab, hv,
                      input logic [15:0] ad);
    int n;
    n = 0;
    m0 = mw;
    r0 = rs;
    call_req <= 1'b1;
    call_addr <= ad;
    call_op <= op;
    call_keyed <= kd;
    secure_deny <= dn;
    @(posedge clk);
    call_req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (n == 4) irq_pin <= ab;
      if (n == 4) hv_fault_pin <= hv;
    end while (!result_valid && !mcu_reset && n < 200);
    res = {result_carry, result_status};
    irq_pin <= 1'b0;
    hv_fault_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task t_regs();
    chk("permit forced", write_permit, 1);
    axr(A_BOOTST);
    chk("boot status", rd, BOOTST_RST);
    axr(A_CYCLE);
    chk("cycle len", rd, CYCLE_RST);
    axw(8'h3c, 32'h1);
    chk("unmapped wr", resp, RESP_SLVERR);
    axr(8'h3c);
    chk("unmapped rd", {rd[29:0], resp}, RESP_SLVERR);
    $display("test regs done");
  endtask
  task t_perm();
    axw(A_BOOTST, 32'h80);
    chk("activate", write_permit, 0);
    axw(A_CMD, {24'h0, CMD_SET_WE});
    axw(A_KEYDATA, 32'h55);
    chk("bad key", write_permit, 0);
    axw(A_CMD, {24'h0, CMD_SET_WE});
    axw(A_BOOTST, 32'h80);
    axw(A_KEYDATA, {24'h0, KEY_VALUE});
    chk("split seq", write_permit, 0);
    setp(CMD_SET_WE);
    chk("set permit", write_permit, 1);
    setp(CMD_CLR_WE);
    chk("clr permit", write_permit, 0);
    $display("test permit done");
  endtask
  task t_call();
    call(OP_PROG, 1'b1, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    chk("no key reset", rs - r0, 1);
    call(OP_CRC, 1'b0, 1'b0, 1'b0, 1'b0, 16'hff00);
    chk("off entry", rs - r0 + mw - m0, 0);
    setp(CMD_SET_WE);
    key();
    call(OP_PROG, 1'b1, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    chk("prog ok", res, 9'h000);
    chk("prog commit", mw - m0, 1);
    chk("permit after", write_permit, 0);
    setp(CMD_SET_WE);
    call(OP_PROG, 1'b1, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    chk("key cleared", rs - r0, 1);
    setp(CMD_CLR_WE);
    key();
    call(OP_PROG, 1'b1, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    chk("no permit", res, 9'h102);
    chk("no permit mem", mw - m0, 0);
    isp_mode <= 1'b1;
    key();
    call(OP_PROG, 1'b1, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    isp_mode <= 1'b0;
    chk("serial prog", res, 9'h000);
    call(OP_CRC, 1'b0, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    chk("crc ok", res, 9'h000);
    $display("test call done");
  endtask
  task t_err();
    logic [3:0] cs [4] = '{4'b1001, 4'b0101, 4'b0011, 4'b0000};
    logic [8:0] ex [4] = '{9'h102, 9'h101, 9'h104, 9'h108};
    int em [4] = '{0, 0, 0, 1};
    for (int i = 0; i < 4; i++) begin
      setp(CMD_SET_WE);
      key();
      readback_ok <= cs[i][0];
      call(OP_PROG, 1'b1, cs[i][3], cs[i][2], cs[i][1], ENTRY_ADDR);
      chk("err status", res, ex[i]);
      chk("err commit", mw - m0, em[i]);
      readback_ok <= 1'b1;
    end
    $display("test errors done");
  endtask
  task t_lock();
    setp(CMD_SET_WE);
    axw(A_BOOTST, 32'hc0);
    axr(A_BOOTST);
    chk("lock set", rd, 32'hc0);
    axw(A_BOOTST, 32'h80);
    axr(A_BOOTST);
    chk("lock holds", rd, 32'hc0);
    key();
    call_cfg <= 1'b1;
    call(OP_CFG, 1'b1, 1'b0, 1'b0, 1'b0, ENTRY_ADDR);
    call_cfg <= 1'b0;
    chk("cfg refused", res, 9'h102);
    axw(A_CTRL, 32'h1);
    axr(A_BOOTST);
    chk("clear barred", rd, 32'hc0);
    icp_mode <= 1'b1;
    repeat (3) @(posedge clk);
    axw(A_CTRL, 32'h1);
    axr(A_BOOTST);
    chk("icp clear", rd, 32'h00);
    icp_mode <= 1'b0;
    repeat (3) @(posedge clk);
    $display("test lock done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_perm();
    t_call();
    t_err();
    t_lock();
    end_of_test();
  end
endmodule
bind fwg_guard fwg_guard_chk i_chk (.clk(clk), .arst_n(arst_n),
  .call_req(call_req), .call_addr(call_addr), .call_op(call_op),
  .call_keyed(call_keyed), .call_cfg(call_cfg), .irq_pin(irq_pin),
  .secure_deny(secure_deny), .cpu_idle(cpu_idle), .mem_write(mem_write),
  .result_valid(result_valid), .result_carry(result_carry),
  .result_status(result_status), .mcu_reset(mcu_reset));
